// ### peorg_pkg.sv
// constants, types and register map of the pre-echo onset refine and gain stage
// What this block does
// - square-sum sub-sub-blocks from first non-echo sub-block
// - lookahead onset: examine one sub-block only
// - first threshold is peak sub-sub energy/8
// - second threshold: reference plus 4x sum, per index
// - reference becomes peak/80 on high zero-crossings
// - onset advances while energy below first threshold and below second threshold or noise
// - moved samples keep last echo-zone gain
// - onset in sub-block 0 or 1: no check
// - onset in sub-block 2: falling high band inhibits
// - later onset: falling full band inhibits
// - later onset: weak high-band rise inhibits
// - low gain ramps linearly over 20 or 4
// - ramp at sub-block starts and onset, from previous sample's raw gain (stored gain at frame start)
// - onset in next frame: no end ramp
// - high-band gain used without interpolation
// - each band multiplied by its own gain
// - output is sum of both attenuated bands
// - 4 sub-sub-blocks at 8 kHz, else 8
// - zero-crossing limit 10 narrowband, else 16
package peorg_pkg;

  // ----------------------------------------------------------------
  // frame geometry
  // ----------------------------------------------------------------
  localparam int NUM_SUB = 8;
  localparam logic [3:0] LOOKAHEAD_IDX = 4'h8;
  localparam logic [8:0] SUB_LEN = 9'h028;
  localparam logic [8:0] FRAME_LEN = 9'h140;
  localparam logic [8:0] TOTAL_LEN = 9'h168;
  localparam int MEM_DEPTH = 360;
  localparam int SSE_DEPTH = 64;
  localparam logic [3:0] NSSF_8K = 4'h4;
  localparam logic [3:0] NSSF_WB = 4'h8;
  localparam logic [8:0] LSSF_8K = 9'h00A;
  localparam logic [8:0] LSSF_WB = 9'h005;
  localparam int EW = 40;

  // ----------------------------------------------------------------
  // thresholds and gains
  // ----------------------------------------------------------------
  localparam int THR1_SHIFT = 3;
  localparam int THR2_SHIFT = 2;
  localparam logic [31:0] PEAK_DIV = 32'h0000_0050;
  localparam logic [39:0] HB3_NUM = 40'h00_0000_000F;
  localparam logic [39:0] HB3_DEN = 40'h00_0000_0002;
  localparam logic [7:0] ZCR_LIM_NB = 8'h0A;
  localparam logic [7:0] ZCR_LIM_WB = 8'h10;
  localparam logic [4:0] SMOOTH_NB = 5'h14;
  localparam logic [4:0] SMOOTH_WB = 5'h04;
  localparam logic [15:0] GAIN_ONE = 16'h8000;
  localparam int GAIN_FRAC = 15;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_FRAMES = 8'h08;
  localparam int CTRL_NB_BIT = 0;
  localparam int CTRL_8K_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] first_nonecho_subblock_index;
    logic [8:0][31:0] full_energy;
    logic [7:0][31:0] highband_subblock_energy;
    logic [31:0] peak_subblock_energy;
    logic [31:0] prev_frame_noise_energy;
    logic [7:0] nonecho_zcr;
    logic [7:0][15:0] initial_low_gain;
    logic [7:0][15:0] initial_high_gain;
  } peorg_frame_t;

  typedef struct packed {
    logic signed [15:0] low;
    logic signed [15:0] high;
  } peorg_sample_t;

  typedef enum {S_IDLE, S_LOAD, S_ENERGY, S_SCAN, S_CHECK, S_EMIT} peorg_state_t;

endpackage

// ### peorg_core.sv
// onset refinement, false-alarm check, low-band smoothing and band mixing
module peorg_core
  import peorg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output wire logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output wire logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output wire logic bvalid,
  input wire logic bready,
  output wire logic [1:0] bresp,
  input wire logic arvalid,
  output wire logic arready,
  input wire logic [7:0] araddr,
  output wire logic rvalid,
  input wire logic rready,
  output wire logic [31:0] rdata,
  output wire logic [1:0] rresp,
  input wire logic frame_start,
  input wire peorg_frame_t frame_info,
  input wire logic in_valid,
  input wire peorg_sample_t in_sample,
  output wire logic in_ready,
  output wire logic out_valid,
  output wire logic signed [17:0] out_sample,
  output wire logic frame_done
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  peorg_state_t state_reg;
  peorg_frame_t info_reg;
  logic [1:0] ctrl_reg;
  logic [15:0] frames_reg;
  logic signed [15:0] mem_lo [MEM_DEPTH];
  logic signed [15:0] mem_hi [MEM_DEPTH];
  logic [EW-1:0] sse [SSE_DEPTH];
  logic [8:0] ptr_reg, onset_reg;
  logic [6:0] jc_reg;
  logic [3:0] sc_reg;
  logic [EW-1:0] acc_reg, max_reg, sum_reg;
  logic adv_reg, inhibit_reg, in_ready_reg;
  logic [15:0] prev_lo_reg, prev_hi_reg, last_raw_reg, sm_old_reg, sm_new_reg;
  logic [4:0] sm_m_reg;
  logic sm_on_reg, out_valid_reg, frame_done_reg;
  logic signed [17:0] out_sample_reg;
  logic awready_reg, wready_reg, aw_got_reg, w_got_reg, bvalid_reg;
  logic arready_reg, rvalid_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg, rdata_reg;
  logic [3:0] w_strb_reg;
  logic [1:0] bresp_reg, rresp_reg;

  // ----------------------------------------------------------------
  // frame-derived values
  // ----------------------------------------------------------------
  logic nb, r8k;
  logic [3:0] m_idx, nssf;
  logic [2:0] pm;
  logic [8:0] lssf, base, e_addr;
  logic [6:0] num;
  logic [7:0] zlim;
  logic [EW-1:0] mcrit_base, peak80, ref_e, noise, cur, e_val;
  logic signed [16:0] x_full;
  logic [33:0] sq;
  logic e_last, below, inh;
  logic [47:0] num2, lhs2;
  logic [31:0] h0, h1, h2, h3, f1, f3;

  assign nb = ctrl_reg[CTRL_NB_BIT];
  assign r8k = ctrl_reg[CTRL_8K_BIT];
  assign m_idx = info_reg.first_nonecho_subblock_index;
  assign pm = (m_idx == 4'h0) ? 3'h0 : 3'(m_idx - 4'h1);
  // sub-sub-block count and length by rate
  // count by rate
  assign nssf = r8k ? NSSF_8K : NSSF_WB;
  assign lssf = r8k ? LSSF_8K : LSSF_WB;
  assign base = 9'(m_idx) * SUB_LEN;
  assign num = (m_idx == 4'h0 || m_idx == LOOKAHEAD_IDX) ? 7'(nssf)
             : 7'(LOOKAHEAD_IDX - m_idx) * 7'(nssf);
  assign e_addr = base + 9'(jc_reg) * lssf + 9'(sc_reg);
  assign x_full = 17'(mem_lo[e_addr]) + 17'(mem_hi[e_addr]);
  assign sq = 34'(x_full * x_full);
  assign e_val = acc_reg + EW'(sq);
  assign e_last = (state_reg == S_ENERGY) && (9'(sc_reg) == lssf - 9'h001);

  assign zlim = nb ? ZCR_LIM_NB : ZCR_LIM_WB;
  assign noise = EW'(info_reg.prev_frame_noise_energy);
  assign mcrit_base = EW'((48'(info_reg.full_energy[pm]) * 48'(info_reg.initial_low_gain[pm]))
                      >> GAIN_FRAC);
  assign peak80 = EW'(info_reg.peak_subblock_energy / PEAK_DIV);
  assign ref_e = (m_idx == 4'h0) ? noise
               : ((peak80 > mcrit_base && info_reg.nonecho_zcr > zlim) ? peak80 : mcrit_base);

  // threshold 2 is compared multiplied through by j+1 to avoid a divider
  assign cur = sse[jc_reg[5:0]];
  assign num2 = 48'(ref_e) + (48'(sum_reg) << THR2_SHIFT);
  assign lhs2 = 48'(cur) * 48'(jc_reg + 7'h01);
  assign below = (cur < (max_reg >> THR1_SHIFT)) && ((cur < noise) || (lhs2 < num2));

  assign h0 = info_reg.highband_subblock_energy[0];
  assign h1 = info_reg.highband_subblock_energy[pm];
  assign h2 = info_reg.highband_subblock_energy[3'(m_idx - 4'h2)];
  assign h3 = info_reg.highband_subblock_energy[3'(m_idx - 4'h3)];
  assign f1 = info_reg.full_energy[4'(pm)];
  assign f3 = info_reg.full_energy[4'(3'(m_idx - 4'h3))];
  always_comb begin
    if (m_idx < 4'h2) begin
      inh = 1'b0;
    end else if (m_idx == 4'h2) begin
      inh = info_reg.highband_subblock_energy[1] < h0;
    end else begin
      inh = (f1 < f3) || (h1 < h3)
         || (HB3_NUM * 40'(h1 - h3) < HB3_DEN * (40'(h1) + 40'(h2) + 40'(h3)));
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= S_IDLE;
      info_reg <= '0;
      in_ready_reg <= 1'b0;
      ptr_reg <= 9'h000;
      jc_reg <= 7'h00;
      sc_reg <= 4'h0;
      acc_reg <= '0;
      max_reg <= '0;
      sum_reg <= '0;
      onset_reg <= 9'h000;
      adv_reg <= 1'b0;
      inhibit_reg <= 1'b0;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (frame_start) begin
            info_reg <= frame_info;
            in_ready_reg <= 1'b1;
            ptr_reg <= 9'h000;
            state_reg <= S_LOAD;
          end
        end
        S_LOAD: begin
          if (in_valid) begin
            ptr_reg <= ptr_reg + 9'h001;
            if (ptr_reg == TOTAL_LEN - 9'h001) begin
              in_ready_reg <= 1'b0;
              jc_reg <= 7'h00;
              sc_reg <= 4'h0;
              acc_reg <= '0;
              max_reg <= '0;
              state_reg <= S_ENERGY;
            end
          end
        end
        S_ENERGY: begin
          if (e_last) begin
            acc_reg <= '0;
            sc_reg <= 4'h0;
            if (e_val > max_reg) begin
              max_reg <= e_val;
            end
            if (jc_reg == num - 7'h01) begin
              jc_reg <= 7'h00;
              sum_reg <= '0;
              adv_reg <= 1'b1;
              onset_reg <= base;
              state_reg <= S_SCAN;
            end else begin
              jc_reg <= jc_reg + 7'h01;
            end
          end else begin
            acc_reg <= e_val;
            sc_reg <= sc_reg + 4'h1;
          end
        end
        S_SCAN: begin
          sum_reg <= sum_reg + cur;
          jc_reg <= jc_reg + 7'h01;
          if (below) begin
            onset_reg <= onset_reg + lssf;
          end else begin
            adv_reg <= 1'b0;
          end
          if (!below || jc_reg == num - 7'h01) begin
            state_reg <= S_CHECK;
          end
        end
        S_CHECK: begin
          inhibit_reg <= inh;
          ptr_reg <= 9'h000;
          state_reg <= S_EMIT;
        end
        S_EMIT: begin
          ptr_reg <= ptr_reg + 9'h001;
          if (ptr_reg == FRAME_LEN - 9'h001) begin
            state_reg <= S_IDLE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // sample store and sub-sub energies carry no reset: written before read
  always_ff @(posedge aclk) begin
    if (state_reg == S_LOAD && in_valid) begin
      mem_lo[ptr_reg] <= in_sample.low;
      mem_hi[ptr_reg] <= in_sample.high;
    end
    if (e_last) begin
      sse[jc_reg[5:0]] <= e_val;
    end
  end

  // ----------------------------------------------------------------
  // gains and mixing
  // ----------------------------------------------------------------
  logic [8:0] n;
  logic [2:0] sb;
  logic [15:0] raw_lo, raw_hi, ext_lo, ext_hi, old_c, new_c, g_lo;
  logic [4:0] m_c, steps;
  logic on_c, bound;
  logic [25:0] s_num;
  logic signed [33:0] mix;

  assign n = ptr_reg;
  assign sb = 3'(n / SUB_LEN);
  assign ext_lo = (m_idx == 4'h0) ? prev_lo_reg : info_reg.initial_low_gain[pm];
  assign ext_hi = (m_idx == 4'h0) ? prev_hi_reg : info_reg.initial_high_gain[pm];
  assign raw_lo = inhibit_reg ? GAIN_ONE : (n < base) ? info_reg.initial_low_gain[sb]
                : (n < onset_reg) ? ext_lo : GAIN_ONE;
  assign raw_hi = inhibit_reg ? GAIN_ONE : (n < base) ? info_reg.initial_high_gain[sb]
                : (n < onset_reg) ? ext_hi : GAIN_ONE;
  // an onset at or past the frame end never matches n, so no ramp at the tail
  // ramp points
  assign bound = (n % SUB_LEN == 9'h000) || (n == onset_reg);
  assign old_c = bound ? ((n == 9'h000) ? prev_lo_reg : last_raw_reg) : sm_old_reg;
  assign new_c = bound ? raw_lo : sm_new_reg;
  assign m_c = bound ? 5'h00 : sm_m_reg;
  assign on_c = bound || sm_on_reg;
  assign steps = nb ? SMOOTH_NB : SMOOTH_WB;
  assign s_num = 26'(steps - m_c) * 26'(old_c) + 26'(m_c + 5'h01) * 26'(new_c);
  assign g_lo = !on_c ? raw_lo
              : nb ? 16'(s_num / (26'(SMOOTH_NB) + 26'h1)) : 16'(s_num / (26'(SMOOTH_WB) + 26'h1));
  assign mix = 34'(mem_lo[n] * $signed({1'b0, g_lo})) + 34'(mem_hi[n] * $signed({1'b0, raw_hi}));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_lo_reg <= GAIN_ONE;
      prev_hi_reg <= GAIN_ONE;
      last_raw_reg <= GAIN_ONE;
      sm_old_reg <= GAIN_ONE;
      sm_new_reg <= GAIN_ONE;
      sm_m_reg <= 5'h00;
      sm_on_reg <= 1'b0;
      out_valid_reg <= 1'b0;
      out_sample_reg <= '0;
      frame_done_reg <= 1'b0;
      frames_reg <= 16'h0000;
    end else begin
      out_valid_reg <= (state_reg == S_EMIT);
      frame_done_reg <= 1'b0;
      if (state_reg == S_EMIT) begin
        out_sample_reg <= mix[32:15];
        last_raw_reg <= raw_lo;
        sm_old_reg <= old_c;
        sm_new_reg <= new_c;
        sm_m_reg <= m_c + 5'h01;
        sm_on_reg <= on_c && (m_c + 5'h01 < steps);
        if (n == FRAME_LEN - 9'h001) begin
          prev_lo_reg <= g_lo;
          prev_hi_reg <= raw_hi;
          frame_done_reg <= 1'b1;
          frames_reg <= frames_reg + 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // register slave
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      ctrl_reg <= CTRL_RESET;
    end else begin
      if (awvalid && awready_reg) begin
        aw_addr_reg <= awaddr;
        aw_got_reg <= 1'b1;
        awready_reg <= 1'b0;
      end
      if (wvalid && wready_reg) begin
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
        w_got_reg <= 1'b1;
        wready_reg <= 1'b0;
      end
      if (bvalid_reg && bready) begin
        bvalid_reg <= 1'b0;
      end
      // one response outstanding at a time; a new pair waits for bready
      if (aw_got_reg && w_got_reg && !bvalid_reg) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
        bvalid_reg <= 1'b1;
        bresp_reg <= (aw_addr_reg == REG_CTRL || aw_addr_reg == REG_STATUS
                      || aw_addr_reg == REG_FRAMES) ? RESP_OKAY : RESP_SLVERR;
        if (aw_addr_reg == REG_CTRL && w_strb_reg[0]) begin
          ctrl_reg <= w_data_reg[1:0];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end else if (arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rresp_reg <= RESP_OKAY;
      case (araddr)
        REG_CTRL: rdata_reg <= {30'h0, ctrl_reg};
        REG_STATUS: rdata_reg <= {14'h0, state_reg != S_IDLE, inhibit_reg, 7'h0, onset_reg};
        REG_FRAMES: rdata_reg <= {16'h0, frames_reg};
        default: begin
          rdata_reg <= 32'h0000_0000;
          rresp_reg <= RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && rready) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign in_ready = in_ready_reg;
  assign out_valid = out_valid_reg;
  assign out_sample = out_sample_reg;
  assign frame_done = frame_done_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  onset_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == S_SCAN && below |=> onset_reg == $past(onset_reg) + $past(lssf))
    else $error("onset did not advance one sub-sub-block");
  onset_floor_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == S_CHECK |-> onset_reg >= base)
    else $error("onset before first non-echo sub-block");
  thr1_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == S_SCAN && cur >= (max_reg >> THR1_SHIFT) |=> !adv_reg && state_reg == S_CHECK)
    else $error("walk passed the first threshold");
  early_skip_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == S_CHECK && m_idx < 4'h2 |=> !inhibit_reg)
    else $error("check made on early onset");
  hb_two_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == S_CHECK && m_idx == 4'h2 && info_reg.highband_subblock_energy[1] < h0
    |=> inhibit_reg)
    else $error("falling high band not inhibited");
  fb_three_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == S_CHECK && m_idx > 4'h2 && f1 < f3 |=> inhibit_reg)
    else $error("falling full band not inhibited");
  ramp_bound_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sm_on_reg |-> sm_m_reg < steps)
    else $error("ramp ran past its length");
  prev_unity_a: assert property (@(posedge aclk)
    !aresetn |=> prev_lo_reg == GAIN_ONE)
    else $error("stored gain not unity after reset");
  frame_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
    frame_done |-> $past(out_valid) && out_valid)
    else $error("frame done without sample stream");
  in_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    in_ready |-> state_reg == S_LOAD)
    else $error("input ready outside load");

endmodule

// ### peorg_upstream.sv
// upstream sample source model feeding the refine and gain stage
module peorg_upstream
  import peorg_pkg::*;
(
  input wire logic aclk,
  input wire logic go,
  input wire logic slow,
  input wire peorg_frame_t info,
  input wire peorg_sample_t smp,
  input wire logic in_ready,
  output logic frame_start,
  output peorg_frame_t frame_info,
  output logic in_valid,
  output peorg_sample_t in_sample
);
  timeunit 1ns;
  timeprecision 1ps;
  int left = 0;
  logic gap = 1'b0;
  initial begin
    frame_start = 1'b0;
    frame_info = '0;
    in_valid = 1'b0;
    in_sample = '0;
  end
  // strobe with index and gains, then 360 samples
  always @(posedge aclk) begin
    int rem;
    rem = go ? 360 : left - int'(in_valid && in_ready);
    left <= rem;
    frame_start <= go;
    if (go) begin
      frame_info <= info;
    end
    // a sample is held until taken; idle data is inverted so stale values never match
    if (!(in_valid && !in_ready)) begin
      gap <= ~gap;
      in_valid <= (rem > 0) && !(slow && gap);
      in_sample <= ((rem > 0) && !(slow && gap)) ? smp : peorg_sample_t'(~smp);
    end
  end
endmodule

// ### peorg_core_tb.sv
// self-checking bench for the pre-echo onset refine and gain stage
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module peorg_core_tb
  import peorg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rdv;
  logic awready, wready, bvalid, arready, rvalid, in_ready, out_valid, frame_done;
  logic [1:0] bresp, rresp, rs;
  logic signed [17:0] out_sample;
  logic frame_start, in_valid, go = 1'b0, slow = 1'b0, chk_out = 1'b0;
  peorg_frame_t frame_info, info = '0;
  peorg_sample_t in_sample, smp = '0;
  int err_total = 0, tests_run = 0, oidx = 0, gl, gh, gprev, i, j, st = 4;
  logic [3:0] tix[5] = '{4'h1, 4'h2, 4'h3, 4'h3, 4'h3};
  logic [31:0] fe0[5] = '{32'h12C, 32'h64, 32'h12C, 32'h64, 32'h64};
  logic [31:0] fe2[5] = '{32'h64, 32'h12C, 32'h64, 32'h12C, 32'h12C};
  logic [31:0] hb0[5] = '{32'hC8, 32'hC8, 32'h64, 32'h64, 32'h64};
  logic [31:0] hb1[5] = '{32'h64, 32'h64, 32'hC8, 32'h64, 32'hC8};
  logic [31:0] hb2[5] = '{32'h64, 32'h3E8, 32'h3E8, 32'h6E, 32'h3E8};
  logic tinh[5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};

  always #5 aclk = ~aclk;

  peorg_core peorg_core_inst (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(4'hF), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .frame_start(frame_start), .frame_info(frame_info), .in_valid(in_valid),
    .in_sample(in_sample), .in_ready(in_ready), .out_valid(out_valid),
    .out_sample(out_sample), .frame_done(frame_done));

  peorg_upstream peorg_upstream_inst (.aclk(aclk), .go(go), .slow(slow), .info(info),
    .smp(smp), .in_ready(in_ready), .frame_start(frame_start), .frame_info(frame_info),
    .in_valid(in_valid), .in_sample(in_sample));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    if (n == 100) begin err_total++; stop_test(); end
  endtask

  task automatic rd(input logic [7:0] a, output logic [1:0] r, output logic [31:0] d);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    r = rresp;
    d = rdata;
    if (n == 100) begin err_total++; stop_test(); end
  endtask

  task automatic frame(input logic c);
    int n;
    chk_out <= c;
    oidx <= 0;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    for (n = 0; n < 5000; n++) begin
      @(posedge aclk);
      if (frame_done) break;
    end
    if (n == 5000) begin err_total++; stop_test(); end
    @(posedge aclk);
    `CHK("samples", 320, oidx)
  endtask

  // ramp from the stored gain over st samples; bands summed before the q15 scaling
  function automatic logic signed [17:0] exp_out(input int k);
    int g;
    g = gl;
    if (k < st) g = ((st - k) * gprev + (k + 1) * gl) / (st + 1);
    return 18'((smp.low * g + smp.high * gh) >>> 15);
  endfunction

  always @(posedge aclk) begin
    if (out_valid) begin
      oidx <= oidx + 1;
      if (chk_out) `CHK("out", exp_out(oidx), out_sample)
    end
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    bready <= 1'b1;
    rready <= 1'b1;
    @(posedge aclk);
    rd(REG_CTRL, rs, rdv);
    `CHK("ctrl reset", 32'h0, rdv)
    wr(REG_CTRL, 32'h3, rs);
    rd(REG_CTRL, rs, rdv);
    `CHK("ctrl", 32'h3, rdv)
    wr(8'h0C, 32'h1, rs);
    `CHK("wr resp", RESP_SLVERR, rs)
    rd(8'h10, rs, rdv);
    `CHK("rd resp", RESP_SLVERR, rs)
    wr(REG_CTRL, 32'h0, rs);
    $display("test regs done");
    // constant samples keep every sub-sub-block at the peak, so the onset stays put
    smp <= '{16'sh0800, 16'sh03E8};
    // onset in the lookahead: the whole frame is echo zone and keeps its given gains
    info.first_nonecho_subblock_index <= 4'h8;
    info.initial_low_gain <= {8{GAIN_ONE}};
    info.initial_high_gain <= {8{16'h4000}};
    gl = 32768;
    gh = 16384;
    gprev = 32768;
    frame(1'b1);
    $display("test high gain done");
    info.initial_low_gain <= {8{16'h4004}};
    info.initial_high_gain <= {8{GAIN_ONE}};
    gl = 16388;
    gh = 32768;
    slow <= 1'b1;
    frame(1'b1);
    $display("test ramp done");
    slow <= 1'b0;
    wr(REG_CTRL, 32'h3, rs);
    info.initial_low_gain <= {8{GAIN_ONE}};
    info.initial_high_gain <= {8{16'h4000}};
    gprev = 16388;
    gl = 32768;
    gh = 16384;
    st = 20;
    frame(1'b1);
    $display("test narrowband done");
    for (i = 0; i < 5; i++) begin
      info.first_nonecho_subblock_index <= tix[i];
      info.full_energy[0] <= fe0[i];
      info.full_energy[1] <= 32'hC8;
      info.full_energy[2] <= fe2[i];
      info.highband_subblock_energy[0] <= hb0[i];
      info.highband_subblock_energy[1] <= hb1[i];
      info.highband_subblock_energy[2] <= hb2[i];
      for (j = 0; j < 8; j++) begin
        info.initial_low_gain[j] <= (j < tix[i]) ? 16'h0CCD : GAIN_ONE;
        info.initial_high_gain[j] <= (j < tix[i]) ? 16'h0CCD : GAIN_ONE;
      end
      frame(1'b0);
      rd(REG_STATUS, rs, rdv);
      `CHK("inhibit", tinh[i], rdv[16])
      `CHK("busy", 1'b0, rdv[17])
      `CHK("onset", 9'(tix[i]) * SUB_LEN, rdv[8:0])
    end
    $display("test regression done");
    rd(REG_FRAMES, rs, rdv);
    `CHK("frames", 16'h0008, rdv[15:0])
    stop_test();
  end
endmodule
